/* File: rtl/encoder_port_access_security.sv */
/*
  Access security for the video encoder unit memory request ports, the
  electronic fence and the register slave on the peripheral bus.
  Assumes bus and request inputs synchronous to mclk; one access per cycle.
*/
`timescale 1ns/100ps
//
// Function
// - sub-ID n owns write bits 2n+1, 2n
// - secure write needs secure enable bit set
// - non-secure write needs its enable; reset zero
// - enable bit 16+n unlocks write bits
// - enable bit n unlocks read bits
// - update enables reset to zero
// - selected sub-ID read at level trips fence
// - trigger bit 16+n picks secure level
// - trigger bit n selects the source
// - protect word selects fenced write/read bits
// - fence copies stored bits for protected sub-IDs
module encoder_port_access_security #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_secure,
  input wire logic [encoder_sec_pkg::SUBID_W-1:0] req_subid,
  output logic req_allow,
  output logic req_block,
  output logic fence_tripped
);
  // ==========================================================
  // register state
  logic [31:0] rd_access_reg, rd_access_next;
  logic [31:0] wr_access_reg, wr_access_next;
  logic [31:0] upd_en_reg, upd_en_next;
  logic [31:0] trig_reg, trig_next;
  logic [31:0] prot_reg, prot_next;
  logic [31:0] ef_rd_reg, ef_rd_next;
  logic [31:0] ef_wr_reg, ef_wr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic allow_reg, allow_next;
  logic block_reg, block_next;
  logic trip_reg, trip_next;
  logic [31:0] rd_unlock, wr_unlock, rd_fence_mask, wr_fence_mask;
  logic [7:0] idx;
  logic setup, wr_setup, mapped, trig_hit;
  logic [4:0] bitsel;

  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_setup = setup && pwrite;
  assign bitsel = {req_subid, req_secure};

  // ==========================================================
  // per-pair masks: one enable bit covers both bits of a sub-ID
  always_comb
  begin
    for (int n = 0; n < encoder_sec_pkg::SUBIDS; n++)
    begin
      rd_unlock[2*n +: 2] = {2{upd_en_reg[n]}};
      wr_unlock[2*n +: 2] = {2{upd_en_reg[encoder_sec_pkg::UPPER_HALF+n]}};
      rd_fence_mask[2*n +: 2] = {2{prot_reg[n]}};
      wr_fence_mask[2*n +: 2] = {2{prot_reg[encoder_sec_pkg::UPPER_HALF+n]}};
    end
  end

  // ==========================================================
  // fence trigger on a selected read at the chosen level
  always_comb
  begin
    trig_hit = req_valid && !req_write && trig_reg[req_subid]
      && (trig_reg[encoder_sec_pkg::UPPER_HALF + req_subid] == req_secure);
  end

  // ==========================================================
  // request decision, registered so outputs come from flops
  always_comb
  begin
    allow_next = 1'b0;
    block_next = 1'b0;
    trip_next = trig_hit;
    if (req_valid)
    begin
      if (req_write)
        allow_next = wr_access_reg[bitsel];
      else
        allow_next = rd_access_reg[bitsel];
      block_next = !allow_next;
    end
  end

  // ==========================================================
  // register file next values; fence copy outranks a bus write
  // so software cannot race the lockdown in the same cycle
  always_comb
  begin
    rd_access_next = rd_access_reg;
    wr_access_next = wr_access_reg;
    upd_en_next = upd_en_reg;
    trig_next = trig_reg;
    prot_next = prot_reg;
    ef_rd_next = ef_rd_reg;
    ef_wr_next = ef_wr_reg;
    if (wr_setup)
    begin
      case (idx)
        encoder_sec_pkg::IDX_READ_ACCESS:
          rd_access_next = (rd_access_reg & ~rd_unlock) | (pwdata & rd_unlock);
        encoder_sec_pkg::IDX_WRITE_ACCESS:
          wr_access_next = (wr_access_reg & ~wr_unlock) | (pwdata & wr_unlock);
        encoder_sec_pkg::IDX_UPDATE_ENABLES: upd_en_next = pwdata;
        encoder_sec_pkg::IDX_FENCE_TRIGGER: trig_next = pwdata;
        encoder_sec_pkg::IDX_FENCE_PROTECT: prot_next = pwdata;
        encoder_sec_pkg::IDX_FENCE_READ_VALUES: ef_rd_next = pwdata;
        encoder_sec_pkg::IDX_FENCE_WRITE_VALUES: ef_wr_next = pwdata;
        default: ;
      endcase
    end
    if (trip_reg)
    begin
      rd_access_next = (rd_access_next & ~rd_fence_mask) | (ef_rd_reg & rd_fence_mask);
      wr_access_next = (wr_access_next & ~wr_fence_mask) | (ef_wr_reg & wr_fence_mask);
    end
  end

  // ==========================================================
  // bus slave: no wait states, answer prepared in the setup cycle
  always_comb
  begin
    mapped = 1'b1;
    case (idx)
      encoder_sec_pkg::IDX_READ_ACCESS: prdata_next = rd_access_reg;
      encoder_sec_pkg::IDX_WRITE_ACCESS: prdata_next = wr_access_reg;
      encoder_sec_pkg::IDX_UPDATE_ENABLES: prdata_next = upd_en_reg;
      encoder_sec_pkg::IDX_FENCE_TRIGGER: prdata_next = trig_reg;
      encoder_sec_pkg::IDX_FENCE_PROTECT: prdata_next = prot_reg;
      encoder_sec_pkg::IDX_FENCE_READ_VALUES: prdata_next = ef_rd_reg;
      encoder_sec_pkg::IDX_FENCE_WRITE_VALUES: prdata_next = ef_wr_reg;
      default:
      begin
        prdata_next = encoder_sec_pkg::RD_UNMAPPED;
        mapped = 1'b0;
      end
    endcase
    if (!setup || pwrite)
      prdata_next = encoder_sec_pkg::RD_UNMAPPED;
    pready_next = setup;
    pslverr_next = setup && !mapped;
  end

  // ==========================================================
  // state registers
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rd_access_reg <= encoder_sec_pkg::RST_ACCESS;
      wr_access_reg <= encoder_sec_pkg::RST_ACCESS;
      upd_en_reg <= encoder_sec_pkg::RST_UPDATE_ENABLES;
      trig_reg <= encoder_sec_pkg::RST_FENCE_TRIGGER;
      prot_reg <= encoder_sec_pkg::RST_FENCE_PROTECT;
      ef_rd_reg <= encoder_sec_pkg::RST_FENCE_VALUES;
      ef_wr_reg <= encoder_sec_pkg::RST_FENCE_VALUES;
      prdata_reg <= encoder_sec_pkg::RD_UNMAPPED;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      allow_reg <= 1'b0;
      block_reg <= 1'b0;
      trip_reg <= 1'b0;
    end
    else
    begin
      rd_access_reg <= rd_access_next;
      wr_access_reg <= wr_access_next;
      upd_en_reg <= upd_en_next;
      trig_reg <= trig_next;
      prot_reg <= prot_next;
      ef_rd_reg <= ef_rd_next;
      ef_wr_reg <= ef_wr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      allow_reg <= allow_next;
      block_reg <= block_next;
      trip_reg <= trip_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign req_allow = allow_reg;
  assign req_block = block_reg;
  assign fence_tripped = trip_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  rst_write_zero_a: assert property ($rose(resetn) |-> wr_access_reg == 32'h0)
    else $error("write enables not zero after reset");
  rst_cfg_zero_a: assert property ($rose(resetn) |-> upd_en_reg == 32'h0)
    else $error("update enables not zero after reset");
  sec_write_gate_a: assert property (req_valid && req_write && req_secure
      && !wr_access_reg[{req_subid, 1'b1}] |=> req_block && !req_allow)
    else $error("secure write passed while disabled");
  nsec_write_gate_a: assert property (req_valid && req_write && !req_secure
      && !wr_access_reg[{req_subid, 1'b0}] |=> req_block && !req_allow)
    else $error("non-secure write passed while disabled");
  write_pair_lock_a: assert property (wr_setup && idx == encoder_sec_pkg::IDX_WRITE_ACCESS
      && !trip_reg |=> (wr_access_reg & ~$past(wr_unlock)) == ($past(wr_access_reg) & ~$past(wr_unlock)))
    else $error("locked write pair changed by bus");
  read_pair_lock_a: assert property (wr_setup && idx == encoder_sec_pkg::IDX_READ_ACCESS
      && !trip_reg |=> (rd_access_reg & ~$past(rd_unlock)) == ($past(rd_access_reg) & ~$past(rd_unlock)))
    else $error("locked read pair changed by bus");
  fence_fire_a: assert property (req_valid && !req_write && trig_reg[req_subid]
      && trig_reg[16 + req_subid] == req_secure |=> fence_tripped)
    else $error("fence missed a matching read");
  fence_level_a: assert property (req_valid && trig_reg[16 + req_subid] != req_secure
      |=> !fence_tripped)
    else $error("fence tripped at wrong level");
  fence_copy_a: assert property (fence_tripped |=>
      ((rd_access_reg ^ $past(ef_rd_reg)) & $past(rd_fence_mask)) == 32'h0
      && ((wr_access_reg ^ $past(ef_wr_reg)) & $past(wr_fence_mask)) == 32'h0)
    else $error("fence copy did not land");
  bus_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
endmodule // encoder_port_access_security

/* File: rtl/encoder_sec_pkg.sv */
/*
  Constants for the encoder port access security block: register indices,
  field positions, reset values and the memory port layout.
  Assumes a 32-bit register bus whose byte address is four times the index.
*/
package encoder_sec_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_READ_ACCESS = 8'h17;
  localparam logic [7:0] IDX_WRITE_ACCESS = 8'h18;
  localparam logic [7:0] IDX_UPDATE_ENABLES = 8'h19;
  localparam logic [7:0] IDX_FENCE_TRIGGER = 8'h1a;
  localparam logic [7:0] IDX_FENCE_PROTECT = 8'h1b;
  localparam logic [7:0] IDX_FENCE_READ_VALUES = 8'h1c;
  localparam logic [7:0] IDX_FENCE_WRITE_VALUES = 8'h1d;
  // ==========================================================
  // field positions
  localparam int SUBIDS = 16;
  localparam int SUBID_W = 4;
  localparam int UPPER_HALF = 16; // write-side / trigger-type half of a word
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ACCESS = 32'h0000_0000;
  localparam logic [31:0] RST_UPDATE_ENABLES = 32'h0000_0000;
  localparam logic [31:0] RST_FENCE_TRIGGER = 32'h0000_0000;
  localparam logic [31:0] RST_FENCE_PROTECT = 32'h0000_0000;
  localparam logic [31:0] RST_FENCE_VALUES = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

/* File: dv/enc_port_model.sv */
/*
  Memory request port model of the encoder sub-units.
  Assumes the bench raises go just after a clock edge for one cycle per request.
*/
`timescale 1ns/100ps
module enc_port_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic wr,
  input wire logic sec,
  input wire logic [encoder_sec_pkg::SUBID_W-1:0] sid,
  output logic req_valid,
  output logic req_write,
  output logic req_secure,
  output logic [encoder_sec_pkg::SUBID_W-1:0] req_subid
);
  logic [5:0] last_reg = 6'h00;
  // ==========================================================
  // request lines
  // idle lines carry the inverse of the last request, so nothing stale can pass;
  // plain always so the declaration value can seed the model without a reset pin
  always @(posedge mclk)
  begin
    if (go)
      last_reg <= {wr, sec, sid};
  end
  assign req_valid = go;
  assign {req_write, req_secure, req_subid} = go ? {wr, sec, sid} : ~last_reg;
endmodule // enc_port_model

/* File: dv/encoder_port_access_security_bench.sv */
/*
  Self-checking bench for the encoder port access security block.
  Assumes the design and enc_port_model; register bus has no wait states.
*/
`timescale 1ns/100ps
module encoder_port_access_security_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, go = 1'b0, wr = 1'b0, sec = 1'b0;
  logic [3:0] sid = 4'h0;
  logic req_valid, req_write, req_secure, req_allow, req_block, fence_tripped;
  logic [3:0] req_subid;
  int n_fail = 0;
  int cmp_count = 0;
  encoder_port_access_security #(.ADDR_W(12)) i_encoder_port_access_security (.mclk(mclk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_write(req_write), .req_secure(req_secure),
    .req_subid(req_subid), .req_allow(req_allow), .req_block(req_block),
    .fence_tripped(fence_tripped));
  enc_port_model i_enc_port_model (.mclk(mclk), .go(go), .wr(wr), .sec(sec), .sid(sid),
    .req_valid(req_valid), .req_write(req_write), .req_secure(req_secure),
    .req_subid(req_subid));
  // ==========================================================
  // clock and watchdog; run needs well under 2000 cycles
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  // ==========================================================
  // compare and bus helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // setup edge, then access phase held until the pready edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    @(posedge mclk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = {2'h0, idx, 2'h0};
    pwdata = d;
    @(posedge mclk);
    #1;
    penable = 1'b1;
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    err = pslverr;
    @(posedge mclk);
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 32'h0, q, e);
    chk("register", exp, q);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  // one request, outcome registered for the following cycle
  task automatic mem(input logic w, input logic s, input logic [3:0] id, input logic ok,
    input logic trip);
    @(posedge mclk);
    #1;
    go = 1'b1;
    wr = w;
    sec = s;
    sid = id;
    @(posedge mclk);
    #1;
    go = 1'b0;
    chk("req_allow", {31'h0, ok}, {31'h0, req_allow});
    chk("req_block", {31'h0, ~ok}, {31'h0, req_block});
    chk("fence_tripped", {31'h0, trip}, {31'h0, fence_tripped});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_locked();
    for (int i = 8'h17; i <= 8'h1b; i++)
      rchk(i[7:0], 32'h0);
    wreg(8'h18, 32'hffff_ffff);
    rchk(8'h18, 32'h0);
    mem(1'b1, 1'b1, 4'h9, 1'b0, 1'b0);
    mem(1'b1, 1'b0, 4'h9, 1'b0, 1'b0);
  endtask
  task automatic t_pairs();
    wreg(8'h19, 32'h0200_0008);
    wreg(8'h18, 32'hffff_ffff);
    rchk(8'h18, 32'h000c_0000);
    wreg(8'h17, 32'hffff_ffff);
    rchk(8'h17, 32'h0000_00c0);
    mem(1'b1, 1'b1, 4'h9, 1'b1, 1'b0);
    mem(1'b1, 1'b0, 4'h8, 1'b0, 1'b0);
    wreg(8'h18, 32'h0008_0000);
    mem(1'b1, 1'b0, 4'h9, 1'b0, 1'b0);
    mem(1'b1, 1'b1, 4'h9, 1'b1, 1'b0);
  endtask
  task automatic t_fence();
    wreg(8'h1a, 32'h0008_0008);
    rchk(8'h1a, 32'h0008_0008);
    wreg(8'h1b, 32'h0200_0008);
    wreg(8'h1c, 32'h0);
    wreg(8'h1d, 32'hffff_ffff);
    mem(1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
    mem(1'b0, 1'b1, 4'h4, 1'b0, 1'b0);
    mem(1'b1, 1'b1, 4'h3, 1'b0, 1'b0);
    mem(1'b0, 1'b1, 4'h3, 1'b1, 1'b1);
    rchk(8'h17, 32'h0);
    rchk(8'h18, 32'h000c_0000);
    mem(1'b0, 1'b1, 4'h3, 1'b0, 1'b1);
  endtask
  // mid-run reset must clear the state that the fence scenario left behind
  task automatic t_reset();
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    rchk(8'h18, 32'h0);
    rchk(8'h19, 32'h0);
    rchk(8'h1a, 32'h0);
    mem(1'b0, 1'b1, 4'h3, 1'b0, 1'b0);
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_locked();
    t_pairs();
    t_fence();
    t_unmapped();
    t_reset();
    tally_and_finish();
  end
endmodule // encoder_port_access_security_bench
